//--- include/sdpr_pkg.sv
/*
 Constants, register map and pin carrier of the pattern readout controller.
 Assumes a 20 MHz pclk and a DDR3 part driven at a slow, divided clock.
*/
package sdpr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PCLK_NS = 50;
    localparam int CK_PERIOD_NS = 400;
    localparam logic [2:0] CK_HALF_CYC = 3'(CK_PERIOD_NS / PCLK_NS / 2);
    localparam logic [3:0] MRS_GAP_CK = 4'hC; // Wait after a mode register set
    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [1:0] OP_ENABLE = 2'h1;
    localparam logic [1:0] OP_DISABLE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam int CTRL_AP = 2;
    localparam int CTRL_CHOP = 3;
    localparam int CTRL_UPPER = 4;
    localparam int CTRL_LOC = 5;
    localparam int CFG_IDLE = 0;
    localparam int CFG_DLL = 1;
    localparam int CFG_OTF = 2;
    localparam int CFG_FIXBC = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PAT = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_DQBAD = 3;
    localparam int STAT_DATA = 8;
    // ------------------------------------------------------------
    // Command pins
    // ------------------------------------------------------------
    localparam logic [2:0] BANK_CAL_MR = 3'h3;
    localparam int MR_EN_BIT = 2;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } sdpr_cmd_t;
    localparam logic [3:0] CODE_NOP = 4'h7;
    localparam logic [3:0] CODE_MRS = 4'h0;
    localparam logic [3:0] CODE_RD = 4'h5;
endpackage

//--- verilog/sdpr_ctrl.sv
/*
 Pattern readout controller: APB slave registers, a divided DDR3 clock,
 command issue on the falling clock edge and capture of pattern beats.
 Assumes the memory is initialised and software reports bank and DLL state.
*/
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module sdpr_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory clock and command
    output logic ck,
    output logic ck_n,
    output logic cke,
    output sdpr_pkg::sdpr_cmd_t cmd,
    // Read data from the memory
    input wire logic [7:0] dq_i,
    input wire logic dqs_i
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD = 4'b0010,
        ST_DATA = 4'b0100,
        ST_GAP = 4'b1000
    } sdpr_state_t;

    // ------------------------------------------------------------
    // Clock divider: commands change on the falling edge of ck
    // ------------------------------------------------------------
    logic [2:0] div_ff, nxt_div;
    logic ck_ff, nxt_ck;
    logic fall_en;
    always_comb
    begin
        nxt_div = div_ff + 3'h1;
        nxt_ck = ck_ff;
        fall_en = 1'b0;
        if (div_ff == sdpr_pkg::CK_HALF_CYC - 3'h1)
        begin
            nxt_div = 3'h0;
            nxt_ck = ~ck_ff;
            fall_en = ck_ff;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_ff <= 3'h0;
            ck_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            ck_ff <= nxt_ck;
        end
    end
    assign ck = ck_ff;
    assign ck_n = ~ck_ff;
    assign cke = 1'b1; // Never powers down or self-refreshes

    // ------------------------------------------------------------
    // Input synchronisers: a change counts once stages 2 and 3 agree
    // ------------------------------------------------------------
    logic [2:0] dqs_sync_ff;
    logic [7:0] dq_sync_ff [3];
    logic dqs_last_ff, nxt_dqs_last;
    logic beat_en;
    always_comb
    begin
        beat_en = (dqs_sync_ff[1] == dqs_sync_ff[2]) && (dqs_sync_ff[2] != dqs_last_ff);
        nxt_dqs_last = beat_en ? dqs_sync_ff[2] : dqs_last_ff;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dqs_sync_ff <= 3'h0;
            dq_sync_ff <= '{default: 8'h00};
            dqs_last_ff <= 1'b0;
        end
        else
        begin
            dqs_sync_ff <= {dqs_sync_ff[1:0], dqs_i};
            dq_sync_ff <= '{dq_i, dq_sync_ff[0], dq_sync_ff[1]};
            dqs_last_ff <= nxt_dqs_last;
        end
    end

    // ------------------------------------------------------------
    // Registers and sequencer
    // ------------------------------------------------------------
    sdpr_state_t st_ff, nxt_st;
    sdpr_pkg::sdpr_cmd_t cmd_ff, nxt_cmd;
    logic [3:0] cfg_ff, nxt_cfg;
    logic pat_ff, nxt_pat;
    logic refused_ff, nxt_refused;
    logic dqbad_ff, nxt_dqbad;
    logic [7:0] data_ff, nxt_data;
    logic [1:0] op_ff, nxt_op;
    logic [6:0] req_ff, nxt_req;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [2:0] beat_ff, nxt_beat;
    logic wr_en, chop;
    // Single-cycle APB access, reads decode the offset combinationally
    always_comb
    begin
        wr_en = psel && penable && pwrite;
        pready = 1'b1;
        pslverr = psel && penable && paddr != sdpr_pkg::OFF_CTRL
            && paddr != sdpr_pkg::OFF_CFG && paddr != sdpr_pkg::OFF_STAT;
        unique case (paddr)
            sdpr_pkg::OFF_CFG: prdata = {28'h000_0000, cfg_ff};
            sdpr_pkg::OFF_STAT: prdata = {16'h0000, data_ff, 4'h0, dqbad_ff, refused_ff,
                pat_ff, st_ff != ST_IDLE};
            default: prdata = 32'h0000_0000;
        endcase
    end
    // Fixed chop or per-command chop when on-the-fly is enabled
    assign chop = cfg_ff[sdpr_pkg::CFG_FIXBC]
        || (cfg_ff[sdpr_pkg::CFG_OTF] && req_ff[sdpr_pkg::CTRL_CHOP]);
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cmd = cmd_ff;
        nxt_cfg = cfg_ff;
        nxt_pat = pat_ff;
        nxt_refused = refused_ff;
        nxt_dqbad = dqbad_ff;
        nxt_data = data_ff;
        nxt_op = op_ff;
        nxt_req = req_ff;
        nxt_cnt = cnt_ff;
        nxt_beat = beat_ff;
        if (wr_en && paddr == sdpr_pkg::OFF_CFG)
            nxt_cfg = pwdata[3:0];
        // Writing one clears the sticky flags; a new event below wins
        if (wr_en && paddr == sdpr_pkg::OFF_STAT)
        begin
            nxt_refused = refused_ff && !pwdata[sdpr_pkg::STAT_REFUSED];
            nxt_dqbad = dqbad_ff && !pwdata[sdpr_pkg::STAT_DQBAD];
        end
        unique case (st_ff)
            ST_IDLE:
                if (wr_en && paddr == sdpr_pkg::OFF_CTRL)
                begin
                    nxt_op = pwdata[1:0];
                    nxt_req = pwdata[6:0];
                    nxt_st = ST_CMD;
                    // Enable needs idle banks and location 00b
                    if (pwdata[1:0] == sdpr_pkg::OP_ENABLE && (!cfg_ff[sdpr_pkg::CFG_IDLE]
                        || pwdata[6:5] != 2'h0 || pat_ff))
                        nxt_st = ST_IDLE;
                    // Reads need a locked DLL and the pattern mode
                    if (pwdata[1:0] == sdpr_pkg::OP_READ && (!cfg_ff[sdpr_pkg::CFG_DLL]
                        || !pat_ff))
                        nxt_st = ST_IDLE;
                    if (pwdata[1:0] == 2'h0 || (pwdata[1:0] == sdpr_pkg::OP_DISABLE && !pat_ff))
                        nxt_st = ST_IDLE;
                    nxt_refused = nxt_refused || nxt_st == ST_IDLE;
                end
            ST_CMD:
                if (fall_en)
                begin
                    nxt_cmd.cs_n = 1'b0;
                    nxt_cmd.addr = 14'h0000;
                    nxt_cnt = 4'h0;
                    if (cmd_ff.cs_n == 1'b0 && {cmd_ff.ras_n, cmd_ff.cas_n, cmd_ff.we_n} != 3'h7)
                    begin
                        // One ck cycle of command, then NOP
                        {nxt_cmd.ras_n, nxt_cmd.cas_n, nxt_cmd.we_n} = sdpr_pkg::CODE_NOP[2:0];
                        nxt_cmd.ba = 3'h0;
                        nxt_st = op_ff == sdpr_pkg::OP_READ ? ST_DATA : ST_GAP;
                        nxt_beat = 3'h0;
                    end
                    else if (op_ff == sdpr_pkg::OP_READ)
                    begin
                        // Column A1:A0 zero, bank zero, A2 picks the chopped half
                        {nxt_cmd.ras_n, nxt_cmd.cas_n, nxt_cmd.we_n} = sdpr_pkg::CODE_RD[2:0];
                        nxt_cmd.ba = 3'h0;
                        nxt_cmd.addr[2] = chop && req_ff[sdpr_pkg::CTRL_UPPER];
                        nxt_cmd.addr[sdpr_pkg::AP_BIT] = req_ff[sdpr_pkg::CTRL_AP];
                        nxt_cmd.addr[sdpr_pkg::BC_BIT] = !chop;
                    end
                    else
                    begin
                        // Mode register set to the calibration register
                        {nxt_cmd.ras_n, nxt_cmd.cas_n, nxt_cmd.we_n} = sdpr_pkg::CODE_MRS[2:0];
                        nxt_cmd.ba = sdpr_pkg::BANK_CAL_MR;
                        nxt_cmd.addr[sdpr_pkg::MR_EN_BIT] = op_ff == sdpr_pkg::OP_ENABLE;
                        nxt_pat = op_ff == sdpr_pkg::OP_ENABLE;
                    end
                end
            ST_DATA:
                if (beat_en)
                begin
                    // Beat n lands in bit n; chopped upper half starts at 4
                    nxt_data[(chop && req_ff[sdpr_pkg::CTRL_UPPER]) ? beat_ff + 3'h4 : beat_ff]
                        = dq_sync_ff[2][0];
                    // Upper pins must copy DQ0 or read zero
                    if (dq_sync_ff[2][7:1] != {7{dq_sync_ff[2][0]}} && dq_sync_ff[2][7:1] != 7'h00)
                        nxt_dqbad = 1'b1;
                    nxt_beat = beat_ff + 3'h1;
                    // Latency is the device's own; the beats themselves end it
                    if (beat_ff == (chop ? 3'h3 : 3'h7))
                        nxt_st = ST_IDLE;
                end
            ST_GAP:
                if (fall_en)
                begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == sdpr_pkg::MRS_GAP_CK - 4'h1)
                        nxt_st = ST_IDLE;
                end
            default: nxt_st = ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= ST_IDLE;
            cmd_ff <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 3'h0,
                addr: 14'h0000}; // Deselected out of reset
            cfg_ff <= sdpr_pkg::CFG_RESET;
            pat_ff <= 1'b0;
            refused_ff <= 1'b0;
            dqbad_ff <= 1'b0;
            data_ff <= 8'h00;
            op_ff <= 2'h0;
            req_ff <= 7'h00;
            cnt_ff <= 4'h0;
            beat_ff <= 3'h0;
        end
        else
        begin
            st_ff <= nxt_st;
            cmd_ff <= nxt_cmd;
            cfg_ff <= nxt_cfg;
            pat_ff <= nxt_pat;
            refused_ff <= nxt_refused;
            dqbad_ff <= nxt_dqbad;
            data_ff <= nxt_data;
            op_ff <= nxt_op;
            req_ff <= nxt_req;
            cnt_ff <= nxt_cnt;
            beat_ff <= nxt_beat;
        end
    end
    assign cmd = cmd_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic is_rd, is_mrs, is_cmd;
    assign is_cmd = !cmd_ff.cs_n && {cmd_ff.ras_n, cmd_ff.cas_n, cmd_ff.we_n} != 3'h7;
    assign is_rd = !cmd_ff.cs_n && {cmd_ff.ras_n, cmd_ff.cas_n, cmd_ff.we_n} == 3'h5;
    assign is_mrs = !cmd_ff.cs_n && {cmd_ff.ras_n, cmd_ff.cas_n, cmd_ff.we_n} == 3'h0;
    property p_enable_idle;
        @(posedge pclk) disable iff (!presetn)
        $rose(is_mrs) && cmd_ff.addr[2] |-> cfg_ff[0] && cmd_ff.addr[1:0] == 2'h0;
    endproperty
    a_enable_idle: assert property (p_enable_idle) else $error("Enable without idle");
    property p_reads_only;
        @(posedge pclk) disable iff (!presetn)
        $past(pat_ff) && is_cmd |-> is_rd || (is_mrs && cmd_ff.ba == 3'h3);
    endproperty
    a_reads_only: assert property (p_reads_only) else $error("Bad command in mode");
    property p_cke;
        @(posedge pclk) disable iff (!presetn)
        pat_ff |-> cke;
    endproperty
    a_cke: assert property (p_cke) else $error("Clock enable low");
    property p_rd_addr;
        @(posedge pclk) disable iff (!presetn)
        is_rd |-> cmd_ff.addr[1:0] == 2'h0 && cmd_ff.ba == 3'h0 && cfg_ff[1] && pat_ff;
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("Read address or state");
    property p_bl8_a2;
        @(posedge pclk) disable iff (!presetn)
        is_rd && cmd_ff.addr[12] |-> !cmd_ff.addr[2] && !cfg_ff[3];
    endproperty
    a_bl8_a2: assert property (p_bl8_a2) else $error("Full burst with A2");
    property p_dll;
        @(posedge pclk) disable iff (!presetn)
        $rose(is_rd) |-> $past(cfg_ff[1]);
    endproperty
    a_dll: assert property (p_dll) else $error("Read before lock");
    property p_one_ck;
        @(posedge pclk) disable iff (!presetn)
        $rose(is_cmd) |-> is_cmd [*8] ##1 !is_cmd && !cmd_ff.cs_n;
    endproperty
    a_one_ck: assert property (p_one_ck) else $error("Command not one ck");
    property p_mrs_mode;
        @(posedge pclk) disable iff (!presetn)
        $rose(is_mrs) |=> pat_ff == cmd_ff.addr[2];
    endproperty
    a_mrs_mode: assert property (p_mrs_mode) else $error("Mode flag mismatch");
    property p_done;
        @(posedge pclk) disable iff (!presetn)
        st_ff == ST_DATA && beat_en && beat_ff == 3'h7 |=> st_ff == ST_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("Burst did not end");
endmodule

//--- verification/sdpr_mem_model.sv
/*
 Behavioural DDR3 memory for the pattern readout bench: command decode,
 calibration mode register and pattern bursts on the strobe and data pins.
 Assumes the controller's divided clock; the bench mirrors MR0 and DLL state.
*/
`timescale 1ns/1ps
module sdpr_mem_model #(
    parameter int READ_LAT = 5,
    parameter logic [7:0] ARRAY_BYTE = 8'h3C
) (
    // Clock and command from the controller
    input wire logic ck,
    input wire logic cke,
    input wire sdpr_pkg::sdpr_cmd_t cmd,
    // Bench knobs: primary mode register chop settings, DLL, pin fault
    input wire logic otf_en,
    input wire logic fix_bc,
    input wire logic dll_ok,
    input wire logic dq_fault,
    // Read data and observation
    output logic [7:0] dq,
    output logic dqs,
    output logic pat_on,
    output logic [7:0] n_viol
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam logic [7:0] PAT_CAL = 8'hAA; // Beat k is bit k
    logic [2:0] cal_mr_ff;
    logic bank_open, bursting, chop;
    logic [3:0] code;
    assign code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign pat_on = cal_mr_ff[2];
    initial
    begin
        cal_mr_ff = 3'h0;
        {bank_open, bursting, dqs, chop} = 4'h0;
        dq = 8'h00;
        n_viol = 8'h00;
    end

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    // Pattern or array byte; the fault knob breaks the upper-pin copy on purpose
    function automatic logic [7:0] beat_val(input logic [2:0] pos);
        logic b;
        b = pat_on ? (cal_mr_ff[1:0] == 2'h0 && PAT_CAL[pos])
            : ARRAY_BYTE[pos];
        return dq_fault ? {7'h2A, b} : {{7{b}}, b};
    endfunction

    // Data moves a quarter clock after each strobe edge, so it is centred
    task automatic burst(input logic c, input logic upper);
        int n;
        logic [2:0] base;
        n = c ? 4 : 8;
        base = upper ? 3'h4 : 3'h0;
        bursting = 1'b1;
        repeat (READ_LAT - 1) @(posedge ck);
        @(negedge ck);
        dq = beat_val(base);
        for (int k = 0; k < n; k++)
        begin
            @(ck);
            dqs = ~dqs;
            #(sdpr_pkg::CK_PERIOD_NS / 4);
            dq = (k == n - 1) ? ~dq : beat_val(base + 3'(k + 1));
        end
        bursting = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Released data pins flip each clock so a stale value never looks valid
    always @(posedge ck)
    begin
        if (!bursting)
            dq = ~dq;
        if (pat_on && !cke)
            n_viol = n_viol + 8'h01;
        if (!cmd.cs_n && code != sdpr_pkg::CODE_NOP)
        begin
            if (code == sdpr_pkg::CODE_MRS)
            begin
                if (bank_open)
                    n_viol = n_viol + 8'h01;
                if (cmd.ba == sdpr_pkg::BANK_CAL_MR)
                    cal_mr_ff = cmd.addr[2:0];
            end
            else if (code == sdpr_pkg::CODE_RD)
            begin
                chop = fix_bc | (otf_en & !cmd.addr[sdpr_pkg::BC_BIT]);
                if (!dll_ok || bursting)
                    n_viol = n_viol + 8'h01;
                if (pat_on && (cmd.addr[1:0] != 2'h0 || (!chop && cmd.addr[2])))
                    n_viol = n_viol + 8'h01;
                // Auto precharge and bank bits play no part here
                fork
                    burst(chop, chop & cmd.addr[2]);
                join_none
            end
            else if (pat_on)
                n_viol = n_viol + 8'h01;
            else
                bank_open = (code == 4'h3) ? 1'b1 : (code == 4'h2) ? 1'b0 : bank_open;
        end
    end
endmodule

//--- verification/tb_top.sv
/*
 Self-checking bench of the pattern readout controller: APB tasks, the
 behavioural memory, refusal and burst scenarios with mid-run resets.
 Assumes zero-wait APB answers and a 20 MHz pclk.
*/
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int LIMIT = 20000; // Cycles; the run needs a few thousand
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic ck, ck_n, cke, dqs, otf_en, fix_bc, dll_ok, dq_fault, pat_on;
    logic [7:0] paddr, dq, n_viol;
    logic [31:0] pwdata, prdata, q;
    sdpr_pkg::sdpr_cmd_t cmd;
    int n_fail, n_tests, cyc;
    sdpr_ctrl sdpr_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ck(ck), .ck_n(ck_n), .cke(cke), .cmd(cmd), .dq_i(dq),
        .dqs_i(dqs));
    sdpr_mem_model sdpr_mem_model_i (.ck(ck), .cke(cke), .cmd(cmd), .otf_en(otf_en),
        .fix_bc(fix_bc), .dll_ok(dll_ok), .dq_fault(dq_fault), .dq(dq), .dqs(dqs),
        .pat_on(pat_on), .n_viol(n_viol));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // One APB transfer; read data is taken in the same edge that sees pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(nm, exp, q & m);
    endtask

    // Polls busy under a bound; a stuck busy shows up as a mismatch
    task automatic op(input logic [31:0] ctrl);
        int i;
        i = 0;
        xfer(1'b1, sdpr_pkg::OFF_CTRL, ctrl);
        do
        begin
            xfer(1'b0, sdpr_pkg::OFF_STAT, 32'h0000_0000);
            i++;
        end
        while (q[0] !== 1'b0 && i < 200);
        chk("busy", 32'h0000_0000, {31'h0, q[0]});
    endtask

    // The memory knobs follow CFG so both sides agree on chop and DLL
    task automatic set_cfg(input logic [3:0] c);
        xfer(1'b1, sdpr_pkg::OFF_CFG, {28'h0, c});
        otf_en <= c[sdpr_pkg::CFG_OTF];
        fix_bc <= c[sdpr_pkg::CFG_FIXBC];
        dll_ok <= c[sdpr_pkg::CFG_DLL];
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            summarize;
        end
    end

    // Tables: refused orders, then burst kinds with their captured bytes
    localparam logic [3:0] RCFG [5] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h2};
    localparam logic [7:0] ROP [5] = '{8'h03, 8'h02, 8'h00, 8'h21, 8'h01};
    localparam logic [3:0] BCFG [6] = '{4'h7, 4'h7, 4'h7, 4'hB, 4'h7, 4'h7};
    localparam logic [7:0] BOP [6] = '{8'h03, 8'h07, 8'h1B, 8'h13, 8'h0B, 8'h03};
    localparam logic [7:0] BDAT [6] = '{8'hAA, 8'hAA, 8'hA0, 8'hA0, 8'h0A, 8'hAA};
    initial
    begin
        {psel, penable, pwrite, otf_en, fix_bc, dll_ok, dq_fault} = 7'h00;
        presetn = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {n_fail, n_tests, cyc} = '0;
        do_reset;
        rd_chk("cfg reset", sdpr_pkg::OFF_CFG, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk("status reset", sdpr_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
        xfer(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, q);
        for (int i = 0; i < 5; i++)
        begin
            set_cfg(RCFG[i]);
            op({24'h0, ROP[i]});
            rd_chk("refused", sdpr_pkg::OFF_STAT, 32'h0000_0006,
                32'h0000_0004);
            xfer(1'b1, sdpr_pkg::OFF_STAT, 32'h0000_0004);
            rd_chk("refused clear", sdpr_pkg::OFF_STAT, 32'h0000_0004, 32'h0000_0000);
        end
        // Each burst kind starts from a fresh reset so captured bits start at zero
        for (int i = 0; i < 6; i++)
        begin
            dq_fault <= (i == 5);
            do_reset;
            set_cfg(BCFG[i]);
            op(32'h0000_0001);
            chk("mem mode on", 32'h0000_0001, {31'h0, pat_on});
            if (i == 0)
            begin
                // A second enable and a read without lock are refused, mode stays on
                op(32'h0000_0001);
                rd_chk("refused again", sdpr_pkg::OFF_STAT, 32'h0000_0006,
                    32'h0000_0006);
                xfer(1'b1, sdpr_pkg::OFF_STAT, 32'h0000_0004);
                set_cfg(4'h5);
                op(32'h0000_0003);
                rd_chk("refused no lock", sdpr_pkg::OFF_STAT, 32'h0000_0006,
                    32'h0000_0006);
                xfer(1'b1, sdpr_pkg::OFF_STAT, 32'h0000_0004);
                set_cfg(BCFG[i]);
            end
            op({24'h0, BOP[i]});
            rd_chk("burst", sdpr_pkg::OFF_STAT, 32'h0000_FF0F, {16'h0, BDAT[i], 4'h0,
                (i == 5), 3'h2});
            op(32'h0000_0002);
            chk("mem mode off", 32'h0000_0000, {31'h0, pat_on});
            rd_chk("mode bit", sdpr_pkg::OFF_STAT, 32'h0000_0002,
                32'h0000_0000);
        end
        // The memory clock pair must stay complementary
        chk("ck pair", 32'h0000_0001, {31'h0, ck ^ ck_n});
        chk("memory violations", 32'h0000_0000, {24'h0, n_viol});
        summarize;
    end
endmodule
